// ===== design/cbd_pkg.sv
// Constants and types shared by the card basic command decoder files.
package cbd_pkg;

    // ------------------------------------------------------------------
    // Command indices
    // ------------------------------------------------------------------
    localparam logic [5:0] CMD_GO_IDLE   = 6'h00;
    localparam logic [5:0] CMD_RSVD_ONE  = 6'h01;
    localparam logic [5:0] CMD_ALL_CID   = 6'h02;
    localparam logic [5:0] CMD_NEW_ADDR  = 6'h03;
    localparam logic [5:0] CMD_SET_DRV   = 6'h04;
    localparam logic [5:0] CMD_RSVD_IO   = 6'h05;
    localparam logic [5:0] CMD_SELECT    = 6'h07;
    localparam logic [5:0] CMD_IF_COND   = 6'h08;
    localparam logic [5:0] CMD_SEND_SPEC = 6'h09;
    localparam logic [5:0] CMD_SEND_ID   = 6'h0a;
    localparam logic [5:0] CMD_LOW_VOLT  = 6'h0b;

    // ------------------------------------------------------------------
    // Argument field positions
    // ------------------------------------------------------------------
    localparam int ARG_ADDR_MSB  = 31;
    localparam int ARG_ADDR_LSB  = 16;
    localparam int ARG_VOLT_MSB  = 11;
    localparam int ARG_VOLT_LSB  = 8;
    localparam int ARG_CHECK_MSB = 7;
    localparam int ARG_CHECK_LSB = 0;

    // ------------------------------------------------------------------
    // Frame layout and timing
    // ------------------------------------------------------------------
    localparam logic [5:0] CMD_FRAME_BITS  = 6'd47;      // Bits after the start bit.
    localparam logic [7:0] RESP_SHORT_BITS = 8'd48;
    localparam logic [7:0] RESP_LONG_BITS  = 8'd136;
    localparam logic [1:0] RESP_WAIT_EDGES = 2'd2;       // Link clocks before a response.
    localparam logic [5:0] RESP_LONG_IDX   = 6'h3f;
    localparam logic [3:0] VOLT_SUPPORTED  = 4'h1;       // Accepted supply-voltage code.

    // ------------------------------------------------------------------
    // Reset values and address generator step
    // ------------------------------------------------------------------
    localparam logic [15:0] RCA_RESET = 16'h0000;
    localparam logic [15:0] DSR_RESET = 16'h0404;
    localparam logic [15:0] RCA_GEN_SEED = 16'h0001;   // Start value of the address generator.
    localparam logic [15:0] RCA_GEN_STEP = 16'h9e37;   // Added to the generator on every clock.

    // ------------------------------------------------------------------
    // Card states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,
        ST_READY = 4'h1,
        ST_IDENT = 4'h2,
        ST_STBY  = 4'h3,
        ST_TRAN  = 4'h4,
        ST_PRG   = 4'h7,
        ST_DIS   = 4'h8
    } cbd_state_type;

endpackage : cbd_pkg

// ===== design/cbd_cmd_receiver.sv
// Command frame receiver that collects one host command from the command line.
`timescale 1ns/10ps
module cbd_cmd_receiver (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        linkRise,
    input  wire logic        cmdBit,
    input  wire logic        rxEnable,
    output logic             frameValid,
    output logic [5:0]       frameIndex,
    output logic [31:0]      frameArg
);
    import cbd_pkg::*;

    logic        rxBusy_q;
    logic        rxBusy_d;
    logic [5:0]  rxCount_q;
    logic [5:0]  rxCount_d;
    logic [46:0] rxShift_q;
    logic [46:0] rxShift_d;
    logic        valid_q;
    logic        valid_d;
    logic [5:0]  index_q;
    logic [5:0]  index_d;
    logic [31:0] arg_q;
    logic [31:0] arg_d;

    // Hunts for a start bit, then shifts the rest of the frame in on rising link edges.
    always_comb begin
        rxBusy_d  = rxBusy_q;
        rxCount_d = rxCount_q;
        rxShift_d = rxShift_q;
        valid_d   = 1'b0;
        index_d   = index_q;
        arg_d     = arg_q;
        if (linkRise) begin
            if (!rxBusy_q) begin
                if (rxEnable && !cmdBit) begin
                    rxBusy_d  = 1'b1;
                    rxCount_d = CMD_FRAME_BITS;
                end
            end else begin
                rxShift_d = {rxShift_q[45:0], cmdBit};
                rxCount_d = rxCount_q - 6'd1;
                if (rxCount_q == 6'd1) begin
                    rxBusy_d = 1'b0;
                    // A frame counts only with host direction and end bits high.
                    valid_d  = rxShift_d[46] && rxShift_d[0];
                    index_d  = rxShift_d[45:40];
                    arg_d    = rxShift_d[39:8];
                end
            end
        end
    end

    // Registers the receiver state.
    always_ff @(posedge clk) begin
        if (rst) begin
            rxBusy_q  <= 1'b0;
            rxCount_q <= 6'h00;
            rxShift_q <= 47'h0;
            valid_q   <= 1'b0;
            index_q   <= 6'h00;
            arg_q     <= 32'h0;
        end else begin
            rxBusy_q  <= rxBusy_d;
            rxCount_q <= rxCount_d;
            rxShift_q <= rxShift_d;
            valid_q   <= valid_d;
            index_q   <= index_d;
            arg_q     <= arg_d;
        end
    end

    assign frameValid = valid_q;
    assign frameIndex = index_q;
    assign frameArg   = arg_q;

endmodule : cbd_cmd_receiver

// ===== design/cbd_decoder.sv
// Basic command decoder of the card: identification, addressing and selection.
// Function
// - Index 0 returns the card to idle, argument ignored, no response.
// - Index 2 answers with a long frame holding the identification register.
// - Index 3 makes a new relative address and returns it in an R6 frame.
// - Index 4 loads the driver-stage register from argument bits 31:16, no response.
// - Index 7 toggles stand-by/transfer or programming/disconnect by current state.
// - Index 7 selects on own address in bits 31:16, deselects on any other.
// - Index 7 with address zero deselects every card.
// - Index 8 checks the voltage code and answers with an R7 frame.
// - Index 9 to the addressed card returns its specific data in a long frame.
// - Index 10 to the addressed card returns its identification in a long frame.
// - Index 11 requests 1.8 V signalling and is acknowledged with an R1 frame.
`timescale 1ns/10ps
module cbd_decoder (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 linkClk,
    input  wire logic                 cmdIn,
    output logic                      cmdOut,
    output logic                      cmdOe,
    input  wire logic [127:0]         idValue,
    input  wire logic [127:0]         specValue,
    input  wire logic                 progBusy,
    output cbd_pkg::cbd_state_type    cardState,
    output logic [15:0]               rcaValue,
    output logic [15:0]               dsrValue,
    output logic                      dsrLoaded,
    output logic                      lowVoltReq
);
    import cbd_pkg::*;

    // ------------------------------------------------------------------
    // Frame builders
    // ------------------------------------------------------------------

    // Short frame, left aligned in the transmit register; check field sent as zero.
    function automatic logic [135:0] shortFrame(input logic [5:0] idx, input logic [31:0] body);
        shortFrame = {2'b00, idx, body, 7'h00, 1'b1, 88'h0};
    endfunction : shortFrame

    // Long frame carrying a 128-bit register whose lowest bit is replaced by the end bit.
    function automatic logic [135:0] longFrame(input logic [127:0] value);
        longFrame = {2'b00, RESP_LONG_IDX, value[127:1], 1'b1};
    endfunction : longFrame

    // ------------------------------------------------------------------
    // Pin synchronisers and link edge detection
    // ------------------------------------------------------------------
    logic [2:0] linkSync_q;
    logic [2:0] linkSync_d;
    logic [1:0] cmdSync_q;
    logic [1:0] cmdSync_d;
    logic       linkRise;
    logic       linkFall;

    // Two flops per pin; the third link flop only remembers the previous level.
    always_comb begin
        linkSync_d = {linkSync_q[1:0], linkClk};
        cmdSync_d  = {cmdSync_q[0], cmdIn};
    end

    // Registers the synchronisers.
    always_ff @(posedge clk) begin
        if (rst) begin
            linkSync_q <= 3'h0;
            cmdSync_q  <= 2'h3;
        end else begin
            linkSync_q <= linkSync_d;
            cmdSync_q  <= cmdSync_d;
        end
    end

    assign linkRise = linkSync_q[1] && !linkSync_q[2];
    assign linkFall = !linkSync_q[1] && linkSync_q[2];

    // ------------------------------------------------------------------
    // Command reception
    // ------------------------------------------------------------------
    logic        cmdValid;
    logic [5:0]  cmdIndex;
    logic [31:0] cmdArg;
    logic        txActive_q;

    cbd_cmd_receiver u_receiver (
        .clk        (clk),
        .rst        (rst),
        .linkRise   (linkRise),
        .cmdBit     (cmdSync_q[1]),
        .rxEnable   (!txActive_q),
        .frameValid (cmdValid),
        .frameIndex (cmdIndex),
        .frameArg   (cmdArg)
    );

    // ------------------------------------------------------------------
    // Command decode and card state
    // ------------------------------------------------------------------
    cbd_state_type state_q;
    cbd_state_type state_d;
    logic [15:0]   rca_q;
    logic [15:0]   rca_d;
    logic [15:0]   dsr_q;
    logic [15:0]   dsr_d;
    logic          dsrLoaded_q;
    logic          dsrLoaded_d;
    logic          lowVolt_q;
    logic          lowVolt_d;
    logic [15:0]   rcaGen_q;
    logic [15:0]   rcaGen_d;
    logic          respStart;
    logic [135:0]  respFrame;
    logic [7:0]    respBits;
    logic [15:0]   argAddr;
    logic          addrMatch;
    logic          selMatch;
    logic [31:0]   statusWord;

    assign argAddr    = cmdArg[ARG_ADDR_MSB:ARG_ADDR_LSB];
    assign addrMatch  = (argAddr == rca_q);
    assign selMatch   = addrMatch && (argAddr != 16'h0000);
    assign statusWord = {19'h0, state_q, 1'b1, 8'h00};

    // Decides the next card state, register loads and any response to send.
    always_comb begin
        state_d     = state_q;
        rca_d       = rca_q;
        dsr_d       = dsr_q;
        dsrLoaded_d = 1'b0;
        lowVolt_d   = 1'b0;
        rcaGen_d    = rcaGen_q + RCA_GEN_STEP;
        respStart   = 1'b0;
        respFrame   = 136'h0;
        respBits    = RESP_SHORT_BITS;
        // Programming ends on its own; a pending deselect then lands in stand-by.
        unique case (state_q)
            ST_TRAN: if (progBusy) state_d = ST_PRG;
            ST_PRG:  if (!progBusy) state_d = ST_TRAN;
            ST_DIS:  if (!progBusy) state_d = ST_STBY;
            default: ;
        endcase
        if (cmdValid) begin
            unique case (cmdIndex)
                CMD_GO_IDLE: begin
                    state_d = ST_IDLE;
                end
                CMD_ALL_CID: begin
                    if (state_q == ST_IDLE || state_q == ST_READY) begin
                        state_d   = ST_IDENT;
                        respStart = 1'b1;
                        respFrame = longFrame(idValue);
                        respBits  = RESP_LONG_BITS;
                    end
                end
                CMD_NEW_ADDR: begin
                    if (state_q == ST_IDENT || state_q == ST_STBY) begin
                        state_d   = ST_STBY;
                        rca_d     = rcaGen_q;
                        respStart = 1'b1;
                        respFrame = shortFrame(CMD_NEW_ADDR, {rcaGen_q, statusWord[15:0]});
                    end
                end
                CMD_SET_DRV: begin
                    dsr_d       = argAddr;
                    dsrLoaded_d = 1'b1;
                end
                CMD_SELECT: begin
                    unique case (state_q)
                        ST_STBY: if (selMatch) state_d = ST_TRAN;
                        ST_TRAN: if (!selMatch) state_d = ST_STBY;
                        ST_DIS:  if (selMatch) state_d = ST_PRG;
                        ST_PRG:  if (!selMatch) state_d = ST_DIS;
                        default: ;
                    endcase
                    // Only the card being selected answers.
                    if (selMatch && (state_q == ST_STBY || state_q == ST_DIS)) begin
                        respStart = 1'b1;
                        respFrame = shortFrame(CMD_SELECT, statusWord);
                    end
                end
                CMD_IF_COND: begin
                    if (state_q == ST_IDLE &&
                        cmdArg[ARG_VOLT_MSB:ARG_VOLT_LSB] == VOLT_SUPPORTED) begin
                        respStart = 1'b1;
                        respFrame = shortFrame(CMD_IF_COND, {20'h0,
                                    cmdArg[ARG_VOLT_MSB:ARG_VOLT_LSB],
                                    cmdArg[ARG_CHECK_MSB:ARG_CHECK_LSB]});
                    end
                end
                CMD_SEND_SPEC: begin
                    if (state_q == ST_STBY && addrMatch) begin
                        respStart = 1'b1;
                        respFrame = longFrame(specValue);
                        respBits  = RESP_LONG_BITS;
                    end
                end
                CMD_SEND_ID: begin
                    if (state_q == ST_STBY && addrMatch) begin
                        respStart = 1'b1;
                        respFrame = longFrame(idValue);
                        respBits  = RESP_LONG_BITS;
                    end
                end
                CMD_LOW_VOLT: begin
                    lowVolt_d = 1'b1;
                    respStart = 1'b1;
                    respFrame = shortFrame(CMD_LOW_VOLT, statusWord);
                end
                default: ;
            endcase
        end
    end

    // Registers the card state.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            rca_q       <= RCA_RESET;
            dsr_q       <= DSR_RESET;
            dsrLoaded_q <= 1'b0;
            lowVolt_q   <= 1'b0;
            rcaGen_q    <= RCA_GEN_SEED;
        end else begin
            state_q     <= state_d;
            rca_q       <= rca_d;
            dsr_q       <= dsr_d;
            dsrLoaded_q <= dsrLoaded_d;
            lowVolt_q   <= lowVolt_d;
            rcaGen_q    <= rcaGen_d;
        end
    end

    // ------------------------------------------------------------------
    // Response transmitter
    // ------------------------------------------------------------------
    logic         txActive_d;
    logic [1:0]   txWait_q;
    logic [1:0]   txWait_d;
    logic [7:0]   txLeft_q;
    logic [7:0]   txLeft_d;
    logic [135:0] txShift_q;
    logic [135:0] txShift_d;
    logic         out_q;
    logic         out_d;
    logic         oe_q;
    logic         oe_d;

    // Waits two falling link edges, then drives one bit per falling edge.
    always_comb begin
        txActive_d = txActive_q;
        txWait_d   = txWait_q;
        txLeft_d   = txLeft_q;
        txShift_d  = txShift_q;
        out_d      = out_q;
        oe_d       = oe_q;
        if (respStart && !txActive_q) begin
            txActive_d = 1'b1;
            txWait_d   = RESP_WAIT_EDGES;
            txLeft_d   = respBits;
            txShift_d  = respFrame;
        end else if (txActive_q && linkFall) begin
            if (txWait_q != 2'd0) begin
                txWait_d = txWait_q - 2'd1;
            end else if (txLeft_q != 8'd0) begin
                out_d     = txShift_q[135];
                oe_d      = 1'b1;
                txShift_d = {txShift_q[134:0], 1'b0};
                txLeft_d  = txLeft_q - 8'd1;
            end else begin
                out_d      = 1'b1;
                oe_d       = 1'b0;
                txActive_d = 1'b0;
            end
        end
    end

    // Registers the transmitter.
    always_ff @(posedge clk) begin
        if (rst) begin
            txActive_q <= 1'b0;
            txWait_q   <= 2'd0;
            txLeft_q   <= 8'd0;
            txShift_q  <= 136'h0;
            out_q      <= 1'b1;
            oe_q       <= 1'b0;
        end else begin
            txActive_q <= txActive_d;
            txWait_q   <= txWait_d;
            txLeft_q   <= txLeft_d;
            txShift_q  <= txShift_d;
            out_q      <= out_d;
            oe_q       <= oe_d;
        end
    end

    assign cmdOut     = out_q;
    assign cmdOe      = oe_q;
    assign cardState  = state_q;
    assign rcaValue   = rca_q;
    assign dsrValue   = dsr_q;
    assign dsrLoaded  = dsrLoaded_q;
    assign lowVoltReq = lowVolt_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence cmdSeen(logic [5:0] idx);
        cmdValid && cmdIndex == idx && !txActive_q;
    endsequence
    sequence pinDriven;
        ##[1:400] cmdOe;
    endsequence

    go_idle_a: assert property (cmdSeen(CMD_GO_IDLE) |=> state_q == ST_IDLE && !txActive_q)
        else $error("Index 0 did not return the card to idle silently.");
    all_id_a: assert property (cmdSeen(CMD_ALL_CID) and (state_q == ST_IDLE)
        |=> txLeft_q == RESP_LONG_BITS ##0 pinDriven)
        else $error("Index 2 did not start a long response.");
    new_addr_a: assert property (cmdSeen(CMD_NEW_ADDR) and (state_q == ST_IDENT)
        |=> rca_q == $past(rcaGen_q) && txShift_q[127:112] == rca_q)
        else $error("Index 3 did not publish the new address.");
    drv_load_a: assert property (cmdSeen(CMD_SET_DRV)
        |=> dsrValue == $past(argAddr) && dsrLoaded && !txActive_q)
        else $error("Index 4 did not load the driver-stage register.");
    select_card_a: assert property (cmdSeen(CMD_SELECT) and (state_q == ST_STBY) and selMatch
        |=> state_q == ST_TRAN && txActive_q)
        else $error("Own address did not select the card.");
    deselect_all_a: assert property (cmdSeen(CMD_SELECT) and (state_q == ST_TRAN)
        and (argAddr == 16'h0000) |=> state_q == ST_STBY && !txActive_q)
        else $error("Address zero did not deselect the card.");
    prog_toggle_a: assert property (cmdSeen(CMD_SELECT) and (state_q == ST_PRG) and !selMatch
        |=> state_q == ST_DIS)
        else $error("Deselect in programming did not enter disconnect.");
    if_cond_a: assert property (cmdSeen(CMD_IF_COND) and (state_q == ST_IDLE)
        |=> txActive_q == ($past(cmdArg[ARG_VOLT_MSB:ARG_VOLT_LSB]) == VOLT_SUPPORTED))
        else $error("Voltage check answered wrongly.");
    spec_read_a: assert property (cmdSeen(CMD_SEND_SPEC) and (state_q == ST_STBY)
        |=> txActive_q == $past(addrMatch))
        else $error("Index 9 answered by the wrong card.");
    id_read_a: assert property (cmdSeen(CMD_SEND_ID) and (state_q == ST_STBY) and addrMatch
        |=> txLeft_q == RESP_LONG_BITS)
        else $error("Index 10 did not start a long response.");
    low_volt_a: assert property (cmdSeen(CMD_LOW_VOLT) |=> lowVoltReq && txActive_q)
        else $error("Index 11 was not acknowledged.");
    reserved_idx_a: assert property ((cmdSeen(CMD_RSVD_ONE) or cmdSeen(CMD_RSVD_IO))
        |=> !txActive_q)
        else $error("A reserved index was answered.");

endmodule : cbd_decoder

// ===== bench/cbd_host_model.sv
// Host model that clocks command frames onto the line and captures responses.
`timescale 1ns/10ps
module cbd_host_model (
    input  wire logic clk,
    input  wire logic cmdOut,
    input  wire logic cmdOe,
    output logic      linkClk,
    output logic      cmdIn
);
    logic hostOe = 1'b0;
    logic hostBit = 1'b1;
    // The line has a pull-up, so it reads high when nobody drives it.
    assign cmdIn = cmdOe ? cmdOut : (hostOe ? hostBit : 1'b1);
    // The link clock stands low between transfers.
    initial linkClk = 1'b0;
    // One link period of 40 system clocks; the card is sampled at the rise.
    task automatic tick(output logic oe, output logic lvl);
        repeat (20) @(negedge clk);
        linkClk = 1'b1;
        oe = cmdOe;
        lvl = cmdIn;
        repeat (20) @(negedge clk);
        linkClk = 1'b0;
    endtask : tick
    // Sends one frame, then clocks on so that a response of rlen bits can come back.
    task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int rlen,
                        output logic [135:0] resp, output int got);
        logic [47:0] frame;
        logic        oe;
        logic        lvl;
        frame = {2'b01, idx, arg, 7'h00, 1'b1};
        resp = '0;
        got = 0;
        hostOe = 1'b1;
        for (int i = 47; i >= 0; i--) begin
            hostBit = frame[i];
            tick(oe, lvl);
        end
        hostOe = 1'b0;
        repeat (rlen + 8) begin
            tick(oe, lvl);
            if (oe) begin
                resp = {resp[134:0], lvl};
                got++;
            end
        end
    endtask : xfer
endmodule : cbd_host_model

// ===== bench/card_basic_command_decoder_tb_top.sv
// Self-checking bench of the card basic command decoder.
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, ac); end end
module card_basic_command_decoder_tb_top;
    import cbd_pkg::*;
    logic          clk = 1'b0, rst = 1'b1, progBusy = 1'b0, dsrSeen = 1'b0, lvSeen = 1'b0;
    logic          linkClk, cmdIn, cmdOut, cmdOe, dsrLoaded, lowVoltReq;
    logic [127:0]  idValue = 128'h0123456789abcdeffedcba9876543210;
    logic [127:0]  specValue = 128'h00112233445566778899aabbccddeeff;
    logic [15:0]   rcaValue, dsrValue, rca;
    logic [135:0]  resp;
    cbd_state_type cardState;
    int            failures = 0, check_count = 0, got;

    cbd_decoder u_cbd_decoder (.clk(clk), .rst(rst), .linkClk(linkClk), .cmdIn(cmdIn),
        .cmdOut(cmdOut), .cmdOe(cmdOe), .idValue(idValue), .specValue(specValue),
        .progBusy(progBusy), .cardState(cardState), .rcaValue(rcaValue),
        .dsrValue(dsrValue), .dsrLoaded(dsrLoaded), .lowVoltReq(lowVoltReq));
    cbd_host_model u_cbd_host_model (.clk(clk), .cmdOut(cmdOut), .cmdOe(cmdOe),
        .linkClk(linkClk), .cmdIn(cmdIn));

    // The 4 ns system clock.
    initial forever #2 clk = ~clk;
    // One-cycle pulses are remembered so a scenario can look at them later.
    always @(posedge clk) begin
        if (dsrLoaded) dsrSeen <= 1'b1;
        if (lowVoltReq) lvSeen <= 1'b1;
    end

    function automatic logic [135:0] shortResp(logic [5:0] idx, logic [31:0] pl);
        return {88'h0, 2'b00, idx, pl, 7'h00, 1'b1};
    endfunction : shortResp
    function automatic logic [135:0] longResp(logic [127:0] v);
        return {2'b00, 6'h3f, v[127:1], 1'b1};
    endfunction : longResp
    function automatic logic [31:0] r1(cbd_state_type st);
        return {19'h0, st, 1'b1, 8'h00};
    endfunction : r1

    // Sends one command and compares the response bits and their count.
    task automatic cmd(string nm, logic [5:0] idx, logic [31:0] arg, int rlen,
                       logic [135:0] ex);
        u_cbd_host_model.xfer(idx, arg, rlen, resp, got);
        `CHK(nm, rlen, got)
        `CHK(nm, ex, resp)
    endtask : cmd

    task automatic test_reset;
        `CHK("state", ST_IDLE, cardState)
        `CHK("rca", RCA_RESET, rcaValue)
        `CHK("dsr", DSR_RESET, dsrValue)
    endtask : test_reset
    task automatic test_ident;
        cmd("rsvd1", CMD_RSVD_ONE, 32'h0, 0, '0);
        cmd("rsvd5", CMD_RSVD_IO, 32'h0, 0, '0);
        cmd("ifbad", CMD_IF_COND, 32'h000002aa, 0, '0);
        cmd("ifok", CMD_IF_COND, 32'h000001a5, 48, shortResp(CMD_IF_COND, 32'h1a5));
        cmd("allid", CMD_ALL_CID, 32'hffffffff, 136, longResp(idValue));
        `CHK("ident", ST_IDENT, cardState)
    endtask : test_ident
    task automatic test_addr;
        u_cbd_host_model.xfer(CMD_NEW_ADDR, 32'h0, 48, resp, got);
        rca = rcaValue;
        `CHK("r6len", 48, got)
        `CHK("r6", shortResp(CMD_NEW_ADDR, {rca, 3'b000, ST_IDENT, 9'h100}), resp)
        `CHK("stby", ST_STBY, cardState)
    endtask : test_addr
    task automatic test_dsr;
        cmd("dsrset", CMD_SET_DRV, 32'hbeef1234, 0, '0);
        `CHK("dsrval", 16'hbeef, dsrValue)
        `CHK("dsrpulse", 1'b1, dsrSeen)
    endtask : test_dsr
    task automatic test_addressed;
        cmd("wrong", CMD_SEND_SPEC, {rca ^ 16'h0001, 16'h0}, 0, '0);
        cmd("spec", CMD_SEND_SPEC, {rca, 16'h0}, 136, longResp(specValue));
        cmd("id", CMD_SEND_ID, {rca, 16'h0}, 136, longResp(idValue));
    endtask : test_addressed
    task automatic test_volt;
        cmd("lowv", CMD_LOW_VOLT, 32'h0, 48, shortResp(CMD_LOW_VOLT, r1(ST_STBY)));
        `CHK("lowvpulse", 1'b1, lvSeen)
    endtask : test_volt
    task automatic test_select;
        cmd("sel", CMD_SELECT, {rca, 16'h0}, 48, shortResp(CMD_SELECT, r1(ST_STBY)));
        `CHK("tran", ST_TRAN, cardState)
        cmd("desel0", CMD_SELECT, 32'h0, 0, '0);
        `CHK("stby0", ST_STBY, cardState)
        cmd("sel2", CMD_SELECT, {rca, 16'h0}, 48, shortResp(CMD_SELECT, r1(ST_STBY)));
        progBusy = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("prg", ST_PRG, cardState)
        cmd("deselx", CMD_SELECT, {rca ^ 16'h0001, 16'h0}, 0, '0);
        `CHK("dis", ST_DIS, cardState)
        cmd("seldis", CMD_SELECT, {rca, 16'h0}, 48, shortResp(CMD_SELECT, r1(ST_DIS)));
        `CHK("prg2", ST_PRG, cardState)
        progBusy = 1'b0;
        repeat (8) @(negedge clk);
        `CHK("tran2", ST_TRAN, cardState)
    endtask : test_select
    task automatic test_idle;
        cmd("idle", CMD_GO_IDLE, 32'hffffffff, 0, '0);
        `CHK("idlest", ST_IDLE, cardState)
    endtask : test_idle

    task automatic report_and_stop;
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Main sequence: reset for 10 cycles, then the scenarios in order.
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (100) @(negedge clk);
        test_reset();
        test_ident();
        test_addr();
        test_dsr();
        test_addressed();
        test_volt();
        test_select();
        test_idle();
        report_and_stop();
    end
    // The scenarios need about 264 us; the watchdog allows 330 us.
    initial begin
        #330000;
        failures++;
        report_and_stop();
    end
endmodule : card_basic_command_decoder_tb_top
